// *** core/pinmux_pkg.sv ***
`default_nettype none
package pinmux_pkg;
    // Function select codes for port C pads
    localparam logic [1:0] FSEL_PERIPH = 2'h0;
    localparam logic [1:0] FSEL_TIMER = 2'h1;
    localparam logic [1:0] FSEL_GPIO = 2'h2;
    // Reset values
    localparam logic [1:0] FSEL_RESET = FSEL_PERIPH;
    localparam logic [7:0] PORTC_PULLUP_RESET = 8'he0;
    localparam logic [7:0] PORTE_PULLUP_RESET = 8'h70;
    localparam logic [2:0] GPIO_DIR_RESET = 3'h0;
    localparam logic [2:0] PORTE_GPIO_SEL_RESET = 3'h0;
    // Field positions
    localparam int PORTC_FIRST_BIT = 5;
    localparam int PORTE_FIRST_BIT = 4;
    localparam int SPI_CLK_IDX = 0;
    localparam int SPI_MOSI_IDX = 1;
    localparam int SPI_MISO_IDX = 2;
endpackage : pinmux_pkg
`default_nettype wire

// *** core/pad_cell_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none
module pad_cell_ctrl
    import pinmux_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic pullup_en_i,
    input wire logic func_oe_i,
    input wire logic func_do_i,
    input wire logic gpio_sel_i,
    input wire logic gpio_dir_out_i,
    input wire logic gpio_do_i,
    output logic oe_o,
    output logic do_o,
    output logic pullup_o
);
    logic oe_reg;
    logic do_reg;
    logic oe_next;
    logic do_next;

    always_comb begin
        oe_next = gpio_sel_i ? gpio_dir_out_i : func_oe_i; // [RQ6]
        do_next = gpio_sel_i ? gpio_do_i : func_do_i;
    end

    // Driver stays off while reset is low
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            oe_reg <= 1'b0; // [RQ8]
            do_reg <= 1'b0;
        end else begin
            oe_reg <= oe_next;
            do_reg <= do_next;
        end
    end

    assign oe_o = oe_reg;
    assign do_o = do_reg;
    assign pullup_o = pullup_en_i;
endmodule : pad_cell_ctrl
`default_nettype wire

// *** core/dec_spi_pinmux.sv ***
// Functional notes
// [RQ1] After reset port C bit 5 routes to decoder 0 phase B; timer A ch1 or GPIO are alternatives.
// [RQ2] After reset port C bit 6 routes to decoder 0 index; timer A ch2 or GPIO are alternatives.
// [RQ3] After reset port C bit 7 routes to decoder 0 home; timer A ch3 or GPIO are alternatives.
// [RQ4] Port C pad pull-ups are on after reset and each is turned off by clearing its control bit.
// [RQ5] Port E pad pull-ups are on after reset and each is turned off by clearing its control bit.
// [RQ6] Every pad in GPIO use has its own input or output direction.
// [RQ7] Port E bit 4 carries the SPI clock, output as master and input as slave.
// [RQ8] Port E bit 5 carries SPI master-out data and its driver is off during reset.
// [RQ9] Master-out data is presented half a clock before the sampling edge of the slave.
// [RQ10] Port E bit 6 carries SPI master-in data, input as master and output as slave.
// [RQ11] An unselected slave holds its master-in pad in high impedance.
// [RQ12] A selected slave drives master-in data half a clock before the master samples it.
// [RQ13] Each pad has a function select that resets to the peripheral default.
`timescale 1ns/10ps
`default_nettype none
module dec_spi_pinmux
    import pinmux_pkg::*;
(
    input wire logic REF_CLK_I,
    input wire logic RSTN_I,
    // Function select, pull-up and GPIO controls
    input wire logic [5:0] PORTC_FSEL_I,
    input wire logic PORTC_FSEL_WE_I,
    input wire logic [2:0] PORTE_GPIO_SEL_I,
    input wire logic PORTE_GPIO_SEL_WE_I,
    input wire logic [7:0] PORTC_PULLUP_CTRL_I,
    input wire logic PORTC_PULLUP_WE_I,
    input wire logic [7:0] PORTE_PULLUP_CTRL_I,
    input wire logic PORTE_PULLUP_WE_I,
    input wire logic [2:0] PORTC_DIR_I,
    input wire logic [2:0] PORTE_DIR_I,
    input wire logic DIR_WE_I,
    input wire logic [2:0] PORTC_IO_DO_I,
    input wire logic [2:0] PORTE_IO_DO_I,
    output logic [2:0] PORTC_IO_DI_O,
    output logic [2:0] PORTE_IO_DI_O,
    // Decoder and timer side
    output logic DEC0_PHASE_B_IN_O,
    output logic DEC0_INDEX_IN_O,
    output logic DEC0_HOME_IN_O,
    input wire logic [2:0] TIMER_A_OUT_I,
    input wire logic [2:0] TIMER_A_OE_I,
    output logic [2:0] TIMER_A_IN_O,
    // SPI side
    input wire logic SPI_MASTER_I,
    input wire logic SPI_SLAVE_SEL_I,
    input wire logic SPI_CLK_OUT_I,
    input wire logic SPI_MOSI_OUT_I,
    input wire logic SPI_MISO_OUT_I,
    output logic SPI_CLK_IN_O,
    output logic SPI_MOSI_IN_O,
    output logic SPI_MISO_IN_O,
    // Pads
    input wire logic [2:0] PORTC_PAD_I,
    output logic [2:0] PORTC_PAD_O,
    output logic [2:0] PORTC_PAD_OE_O,
    output logic [2:0] PORTC_PULLUP_O,
    input wire logic [2:0] PORTE_PAD_I,
    output logic [2:0] PORTE_PAD_O,
    output logic [2:0] PORTE_PAD_OE_O,
    output logic [2:0] PORTE_PULLUP_O
);
    logic [5:0] portc_fsel_reg;
    logic [2:0] porte_gpio_reg;
    logic [7:0] portc_pullup_ctrl_reg;
    logic [7:0] porte_pullup_ctrl_reg;
    logic [2:0] portc_dir_reg;
    logic [2:0] porte_dir_reg;
    logic [2:0] c_oe;
    logic [2:0] c_do;
    logic [2:0] c_gpio;
    logic [2:0] e_foe;
    logic [2:0] e_fdo;

    function automatic logic [1:0] fsel_of(input logic [5:0] f, input int i);
        fsel_of = f[2*i +: 2];
    endfunction : fsel_of

    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            portc_fsel_reg <= {3{FSEL_RESET}}; // [RQ13]
        end else if (PORTC_FSEL_WE_I) begin
            portc_fsel_reg <= PORTC_FSEL_I;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            porte_gpio_reg <= PORTE_GPIO_SEL_RESET; // [RQ13]
        end else if (PORTE_GPIO_SEL_WE_I) begin
            porte_gpio_reg <= PORTE_GPIO_SEL_I;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            portc_pullup_ctrl_reg <= PORTC_PULLUP_RESET; // [RQ4]
        end else if (PORTC_PULLUP_WE_I) begin
            portc_pullup_ctrl_reg <= PORTC_PULLUP_CTRL_I;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            porte_pullup_ctrl_reg <= PORTE_PULLUP_RESET; // [RQ5]
        end else if (PORTE_PULLUP_WE_I) begin
            porte_pullup_ctrl_reg <= PORTE_PULLUP_CTRL_I;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            portc_dir_reg <= GPIO_DIR_RESET;
            porte_dir_reg <= GPIO_DIR_RESET;
        end else if (DIR_WE_I) begin
            portc_dir_reg <= PORTC_DIR_I; // [RQ6]
            porte_dir_reg <= PORTE_DIR_I; // [RQ6]
        end
    end

    // Port C: decoder inputs, timer channels or GPIO
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            c_gpio[i] = (fsel_of(portc_fsel_reg, i) == FSEL_GPIO);
            c_oe[i] = (fsel_of(portc_fsel_reg, i) == FSEL_TIMER) && TIMER_A_OE_I[i];
            c_do[i] = TIMER_A_OUT_I[i];
        end
    end

    assign DEC0_PHASE_B_IN_O = (fsel_of(portc_fsel_reg, 0) == FSEL_PERIPH) & PORTC_PAD_I[0]; // [RQ1]
    assign DEC0_INDEX_IN_O = (fsel_of(portc_fsel_reg, 1) == FSEL_PERIPH) & PORTC_PAD_I[1]; // [RQ2]
    assign DEC0_HOME_IN_O = (fsel_of(portc_fsel_reg, 2) == FSEL_PERIPH) & PORTC_PAD_I[2]; // [RQ3]

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            TIMER_A_IN_O[i] = (fsel_of(portc_fsel_reg, i) == FSEL_TIMER) & PORTC_PAD_I[i];
        end
    end

    assign PORTC_IO_DI_O = c_gpio & PORTC_PAD_I;
    assign PORTE_IO_DI_O = porte_gpio_reg & PORTE_PAD_I;

    // Port E: SPI pad directions
    always_comb begin
        e_foe[SPI_CLK_IDX] = SPI_MASTER_I; // [RQ7]
        e_foe[SPI_MOSI_IDX] = SPI_MASTER_I; // [RQ9]
        e_foe[SPI_MISO_IDX] = !SPI_MASTER_I && SPI_SLAVE_SEL_I; // [RQ10] [RQ11] [RQ12]
        e_fdo[SPI_CLK_IDX] = SPI_CLK_OUT_I;
        e_fdo[SPI_MOSI_IDX] = SPI_MOSI_OUT_I;
        e_fdo[SPI_MISO_IDX] = SPI_MISO_OUT_I;
    end

    assign SPI_CLK_IN_O = !porte_gpio_reg[SPI_CLK_IDX] & PORTE_PAD_I[SPI_CLK_IDX]; // [RQ7]
    assign SPI_MOSI_IN_O = !porte_gpio_reg[SPI_MOSI_IDX] & PORTE_PAD_I[SPI_MOSI_IDX];
    assign SPI_MISO_IN_O = !porte_gpio_reg[SPI_MISO_IDX] & PORTE_PAD_I[SPI_MISO_IDX]; // [RQ10]

    for (genvar g = 0; g < 3; g++) begin : g_pads
        pad_cell_ctrl u_c (
            .clk_i(REF_CLK_I),
            .rstn_i(RSTN_I),
            .pullup_en_i(portc_pullup_ctrl_reg[PORTC_FIRST_BIT + g]), // [RQ4]
            .func_oe_i(c_oe[g]),
            .func_do_i(c_do[g]),
            .gpio_sel_i(c_gpio[g]),
            .gpio_dir_out_i(portc_dir_reg[g]),
            .gpio_do_i(PORTC_IO_DO_I[g]),
            .oe_o(PORTC_PAD_OE_O[g]),
            .do_o(PORTC_PAD_O[g]),
            .pullup_o(PORTC_PULLUP_O[g])
        );
        pad_cell_ctrl u_e (
            .clk_i(REF_CLK_I),
            .rstn_i(RSTN_I),
            .pullup_en_i(porte_pullup_ctrl_reg[PORTE_FIRST_BIT + g]), // [RQ5]
            .func_oe_i(e_foe[g]),
            .func_do_i(e_fdo[g]),
            .gpio_sel_i(porte_gpio_reg[g]),
            .gpio_dir_out_i(porte_dir_reg[g]),
            .gpio_do_i(PORTE_IO_DO_I[g]),
            .oe_o(PORTE_PAD_OE_O[g]),
            .do_o(PORTE_PAD_O[g]),
            .pullup_o(PORTE_PULLUP_O[g])
        );
    end

    // Checks
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RSTN_I);

    sequence fresh_c_pullup_clear(int b);
        PORTC_PULLUP_WE_I && !PORTC_PULLUP_CTRL_I[b];
    endsequence

    pullup_c_off_a: assert property (fresh_c_pullup_clear(5) |=> !PORTC_PULLUP_O[0]) // [RQ4]
        else $error("port C pull-up not released");
    pullup_e_off_a: assert property (PORTE_PULLUP_WE_I && !PORTE_PULLUP_CTRL_I[6]
        |=> !PORTE_PULLUP_O[2]) // [RQ5]
        else $error("port E pull-up not released");
    miso_unsel_hiz_a: assert property (!SPI_MASTER_I && !SPI_SLAVE_SEL_I && !porte_gpio_reg[2]
        |=> !PORTE_PAD_OE_O[2]) // [RQ11]
        else $error("unselected slave drives master-in pad");
    miso_slave_drive_a: assert property (!SPI_MASTER_I && SPI_SLAVE_SEL_I && !porte_gpio_reg[2]
        |=> PORTE_PAD_OE_O[2] && PORTE_PAD_O[2] == $past(SPI_MISO_OUT_I)) // [RQ12]
        else $error("selected slave not driving master-in");
    clk_master_out_a: assert property (SPI_MASTER_I && !porte_gpio_reg[0]
        |=> PORTE_PAD_OE_O[0]) // [RQ7]
        else $error("clock pad not driven as master");
    mosi_master_data_a: assert property (SPI_MASTER_I && !porte_gpio_reg[1]
        |=> PORTE_PAD_O[1] == $past(SPI_MOSI_OUT_I)) // [RQ9]
        else $error("master-out data wrong");
    gpio_dir_a: assert property (c_gpio[1] |=> PORTC_PAD_OE_O[1] == $past(portc_dir_reg[1])) // [RQ6]
        else $error("GPIO direction ignored");
    phase_b_route_a: assert property (fsel_of(portc_fsel_reg, 0) == FSEL_PERIPH
        |-> DEC0_PHASE_B_IN_O == PORTC_PAD_I[0] && !TIMER_A_IN_O[0]) // [RQ1]
        else $error("phase B routing wrong");
    index_route_a: assert property (fsel_of(portc_fsel_reg, 1) == FSEL_TIMER
        |-> !DEC0_INDEX_IN_O && TIMER_A_IN_O[1] == PORTC_PAD_I[1]) // [RQ2]
        else $error("index routing wrong");
    home_route_a: assert property (c_gpio[2] |-> !DEC0_HOME_IN_O && !TIMER_A_IN_O[2]) // [RQ3]
        else $error("home routing wrong");
endmodule : dec_spi_pinmux
`default_nettype wire

// *** testbench/enc_spi_peer.sv ***
`timescale 1ns/10ps
`default_nettype none
module enc_spi_peer (
    input wire logic [2:0] c_oe_i,
    input wire logic [2:0] c_do_i,
    input wire logic [2:0] e_oe_i,
    input wire logic [2:0] e_do_i,
    input wire logic [2:0] c_drv_i,
    input wire logic [2:0] e_drv_i,
    output logic [2:0] c_pad_o,
    output logic [2:0] e_pad_o
);
    // Peer drives a pad only where the device has released it
    always_comb begin
        for (int b = 0; b < 3; b++) begin
            c_pad_o[b] = c_oe_i[b] ? c_do_i[b] : c_drv_i[b];
            e_pad_o[b] = e_oe_i[b] ? e_do_i[b] : e_drv_i[b];
        end
    end
endmodule : enc_spi_peer
`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import pinmux_pkg::*;
    logic clk = 1'b0, rstn = 1'b1, c_fsel_we = 1'b0, e_sel_we = 1'b0, c_pu_we = 1'b0;
    logic e_pu_we = 1'b0, dir_we = 1'b0, master = 1'b0, ssel = 1'b0, s_clk = 1'b0;
    logic s_mosi = 1'b0, s_miso = 1'b0;
    logic [5:0] c_fsel = 6'h00;
    logic [7:0] c_pu = 8'he0, e_pu = 8'h70;
    logic [2:0] e_sel = 3'h0, c_dir = 3'h0, e_dir = 3'h0, c_do = 3'h0, e_do = 3'h0;
    logic [2:0] t_out = 3'h0, t_oe = 3'h0, c_drv = 3'h5, e_drv = 3'h2;
    wire logic [2:0] c_di, e_di, t_in, c_pad, c_po, c_oe, c_puo, e_pad, e_po, e_oe, e_puo;
    wire logic dec_b, dec_i, dec_h, s_clk_in, s_mosi_in, s_miso_in;
    int n_errors = 0;
    int total_checks = 0;
    dec_spi_pinmux uut (.REF_CLK_I(clk), .RSTN_I(rstn), .PORTC_FSEL_I(c_fsel),
        .PORTC_FSEL_WE_I(c_fsel_we), .PORTE_GPIO_SEL_I(e_sel), .PORTE_GPIO_SEL_WE_I(e_sel_we),
        .PORTC_PULLUP_CTRL_I(c_pu), .PORTC_PULLUP_WE_I(c_pu_we), .PORTE_PULLUP_CTRL_I(e_pu),
        .PORTE_PULLUP_WE_I(e_pu_we), .PORTC_DIR_I(c_dir), .PORTE_DIR_I(e_dir),
        .DIR_WE_I(dir_we), .PORTC_IO_DO_I(c_do), .PORTE_IO_DO_I(e_do), .PORTC_IO_DI_O(c_di),
        .PORTE_IO_DI_O(e_di), .DEC0_PHASE_B_IN_O(dec_b), .DEC0_INDEX_IN_O(dec_i),
        .DEC0_HOME_IN_O(dec_h), .TIMER_A_OUT_I(t_out), .TIMER_A_OE_I(t_oe),
        .TIMER_A_IN_O(t_in), .SPI_MASTER_I(master), .SPI_SLAVE_SEL_I(ssel),
        .SPI_CLK_OUT_I(s_clk), .SPI_MOSI_OUT_I(s_mosi), .SPI_MISO_OUT_I(s_miso),
        .SPI_CLK_IN_O(s_clk_in), .SPI_MOSI_IN_O(s_mosi_in), .SPI_MISO_IN_O(s_miso_in),
        .PORTC_PAD_I(c_pad), .PORTC_PAD_O(c_po), .PORTC_PAD_OE_O(c_oe),
        .PORTC_PULLUP_O(c_puo), .PORTE_PAD_I(e_pad), .PORTE_PAD_O(e_po),
        .PORTE_PAD_OE_O(e_oe), .PORTE_PULLUP_O(e_puo));
    enc_spi_peer peer (.c_oe_i(c_oe), .c_do_i(c_po), .e_oe_i(e_oe), .e_do_i(e_po),
        .c_drv_i(c_drv), .e_drv_i(e_drv), .c_pad_o(c_pad), .e_pad_o(e_pad));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic test_done;
        if (n_errors == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : test_done
    task automatic t_reset;
        #1;
        rstn = 1'b0;
        step(1);
        chk({2'h0, c_oe, e_oe}, 8'h00);
        chk({2'h0, c_puo, e_puo}, 8'h3f);
        step(1);
        rstn = 1'b1;
        step(1);
        chk({2'h0, dec_h, dec_i, dec_b, t_in}, {2'h0, c_drv, 3'h0});
        chk({2'h0, s_miso_in, s_mosi_in, s_clk_in, e_oe}, {2'h0, e_drv, 3'h0});
    endtask : t_reset
    task automatic t_pullup;
        logic [7:0] v [3] = '{8'h60, 8'ha0, 8'hc0};
        c_pu_we = 1'b1;
        e_pu_we = 1'b1;
        for (int k = 0; k < 3; k++) begin
            c_pu = v[k];
            e_pu = v[k] >> 1;
            step(1);
            chk({2'h0, c_puo, e_puo}, {2'h0, v[k][7:5], v[k][7:5]});
        end
        c_pu_we = 1'b0;
        e_pu_we = 1'b0;
    endtask : t_pullup
    task automatic t_timer;
        c_fsel = 6'h15;
        c_fsel_we = 1'b1;
        t_out = 3'h6;
        t_oe = 3'h3;
        step(1);
        c_fsel_we = 1'b0;
        step(1);
        chk({2'h0, c_oe, c_po & c_oe}, {2'h0, 3'h3, 3'h2});
        chk({2'h0, dec_h, dec_i, dec_b, t_in}, 8'h06);
    endtask : t_timer
    task automatic t_gpio;
        c_fsel = 6'h2a;
        c_fsel_we = 1'b1;
        e_sel = 3'h7;
        e_sel_we = 1'b1;
        c_dir = 3'h5;
        e_dir = 3'h2;
        dir_we = 1'b1;
        c_do = 3'h7;
        e_do = 3'h7;
        step(1);
        c_fsel_we = 1'b0;
        e_sel_we = 1'b0;
        dir_we = 1'b0;
        step(1);
        chk({2'h0, c_oe, e_oe}, 8'h2a);
        chk({2'h0, c_di, e_di}, 8'h2a);
        chk({5'h0, t_in}, 8'h00);
        c_fsel = 6'h3f;
        c_fsel_we = 1'b1;
        step(1);
        c_fsel_we = 1'b0;
        step(1);
        chk({2'h0, c_oe, c_di}, 8'h00);
        chk({2'h0, dec_h, dec_i, dec_b, t_in}, 8'h00);
    endtask : t_gpio
    task automatic t_spi;
        e_sel = 3'h0;
        e_sel_we = 1'b1;
        master = 1'b1;
        s_clk = 1'b1;
        s_mosi = 1'b1;
        e_drv = 3'h4;
        step(1);
        e_sel_we = 1'b0;
        step(1);
        chk({2'h0, e_oe, e_po & e_oe}, 8'h1b);
        chk({7'h0, s_miso_in}, 8'h01);
        master = 1'b0;
        s_miso = 1'b1;
        e_drv = 3'h3;
        step(2);
        chk({5'h0, e_oe}, 8'h00);
        chk({5'h0, s_miso_in, s_mosi_in, s_clk_in}, 8'h03);
        ssel = 1'b1;
        e_drv = 3'h0;
        step(2);
        chk({2'h0, e_oe, e_po & e_oe}, 8'h24);
    endtask : t_spi
    task automatic t_rst_mid;
        master = 1'b1;
        step(1);
        chk({5'h0, e_oe}, 8'h03);
        rstn = 1'b0;
        step(1);
        chk({2'h0, c_oe, e_oe}, 8'h00);
        chk({2'h0, c_puo, e_puo}, 8'h3f);
        chk({2'h0, dec_h, dec_i, dec_b, t_in}, {2'h0, c_drv, 3'h0});
        rstn = 1'b1;
        step(1);
        chk({5'h0, e_oe}, 8'h03);
    endtask : t_rst_mid
    initial begin
        t_reset;
        t_pullup;
        t_timer;
        t_gpio;
        t_spi;
        t_rst_mid;
        test_done;
    end
    initial begin
        #2000;
        n_errors++;
        test_done;
    end
endmodule : tb_top
`default_nettype wire
